// ===== src/err_event_log.v
`timescale 1ns/1ns
// ==========================================================================
// Sticky status flags: hardware set wins over a software clear
`include "err_fsm_defs.vh"
module err_event_log
(
   input  wire                  clk,
   input  wire                  rst,
   input  wire [`ST_NUM-1:0]    set_in,
   input  wire [`ST_NUM-1:0]    clr_in,
   output wire [`ST_NUM-1:0]    flags
);
   genvar i;
   generate
      for (i = 0; i < `ST_NUM; i = i + 1)
      begin : g_flag
         reg flag_q;
         always @(posedge clk or posedge rst)
         begin
            if (rst)
               flag_q <= 1'b0;
            else if (set_in[i])
               flag_q <= 1'b1;
            else if (clr_in[i])
               flag_q <= 1'b0;
         end
         assign flags[i] = flag_q;
      end
   endgenerate
endmodule

// ===== src/err_fsm_defs.vh
`ifndef ERR_FSM_DEFS_VH
`define ERR_FSM_DEFS_VH

// ==========================================================================
// Register map (APB byte addresses)
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_SWITCH      12'h008
`define OFF_SLOTS       12'h00c
`define OFF_TASKFILE    12'h010
`define OFF_STATE       12'h014
`define OFF_QUEUED      12'h018

// ==========================================================================
// Control register fields
`define CTRL_RUN        0
`define CTRL_FBS_EN     1

// ==========================================================================
// Status register fields (error flags write one to clear; CR is read-only)
`define ST_IFS          0
`define ST_INFS         1
`define ST_TFES         2
`define ST_OFS          3
`define ST_IPMS         4
`define ST_CR           8
`define ST_NUM          5

// ==========================================================================
// Switching register fields
`define SW_SDE          0
`define SW_DWE_LO       8
`define SW_DWE_HI       11

// ==========================================================================
// Taskfile status bits
`define TF_BSY          7
`define TF_DRQ          3

// ==========================================================================
// Widths and resets
`define SLOT_W          32
`define DEV_W           4
`define ZERO32          32'h0000_0000
`define ZERO4           4'h0
`define ZERO8           8'h00
`define ZERO16          16'h0000
`define NUM_STATES      9

`endif

// ===== src/port_error_handling_fsm.v
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "err_fsm_defs.vh"
// Notes on behaviour
// - Sending or receiving a loop-test activate frame enters the loop-test state.
// - Loop-test state is left only when software clears port run enable.
// - Fatal condition persists until software clears port run enable.
// - Escape of a received frame sets interface fatal flag.
// - Escape of a sent data frame sets interface fatal flag.
// - Escape of sent non-data frame: fatal, or non-fatal plus single-drive error when switching.
// - Error reply to sent data frame sets fatal; posting may continue.
// - Error reply to sent non-data frame sets non-fatal flag.
// - CRC error on received data frame sets fatal; posting still allowed.
// - CRC error on received non-data frame sets non-fatal flag.
// - Device-bits frame with error updates queued slots, sets taskfile error, switching extras.
// - Register frame with error sets taskfile error, plus switching extras.
// - PIO setup frame with error sets taskfile error, plus switching extras.
// - DMA setup frame with no active slot sets interface fatal flag.
// - Other received frames with no active slot are dropped silently.
// - Overflow sets overflow flag, plus switching extras.
// - Underflow only records byte count; no error flag.
// - Invalid multiplier port field sets bad-port flag, then non-fatal handling.
// - Escape of sent register/data frame clears busy and request, copies, sets fatal.
// - An escaped transmitted frame is never retransmitted.
// - Escape handling leaves command issue bits untouched.
// - With switching, escape of sent register frame is non-fatal, single-drive error path.
// - After non-fatal handling return to idle or switching idle.
// - After fatal, list running bit clears once run enable is cleared.
module port_error_handling_fsm
(
   input  wire                  clk,
   input  wire                  rst,
   // APB slave
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [11:0]           paddr,
   input  wire [31:0]           pwdata,
   output wire                  pready,
   output reg  [31:0]           prdata,
   output wire                  pslverr,
   // Link and transport events, one-cycle pulses
   input  wire                  loop_test_start,
   input  wire                  esc_rx_frame,
   input  wire                  esc_tx_data,
   input  wire                  esc_tx_reg,
   input  wire                  esc_tx_other,
   input  wire                  rerr_tx_data,
   input  wire                  rerr_tx_nondata,
   input  wire                  crc_rx_data,
   input  wire                  crc_rx_nondata,
   input  wire                  sdb_err,
   input  wire [31:0]           sdb_clear_slots,
   input  wire                  reg_err,
   input  wire                  pio_err,
   input  wire                  dma_setup_rx,
   input  wire                  other_rx,
   input  wire                  overflow,
   input  wire                  underflow,
   input  wire [15:0]           xfer_bytes,
   input  wire                  bad_pm_port,
   input  wire [3:0]            frame_dev,
   input  wire                  list_start,
   // Datapath controls and header update
   output wire                  post_enable,
   output wire                  drop_frame,
   output wire                  retransmit_block,
   output reg                   byte_count_we,
   output reg  [15:0]           byte_count,
   output reg                   internal_busy_copy,
   output reg                   internal_request_copy
);
   // =======================================================================
   // States
   localparam [8:0] S_IDLE     = 9'b0_0000_0001;
   localparam [8:0] S_SW_IDLE  = 9'b0_0000_0010;
   localparam [8:0] S_LOOP     = 9'b0_0000_0100;
   localparam [8:0] S_BADPM    = 9'b0_0000_1000;
   localparam [8:0] S_ESC_FAT  = 9'b0_0001_0000;
   localparam [8:0] S_ESC_SW   = 9'b0_0010_0000;
   localparam [8:0] S_ONE_DRV  = 9'b0_0100_0000;
   localparam [8:0] S_NONFAT   = 9'b0_1000_0000;
   localparam [8:0] S_WAIT_CLR = 9'b1_0000_0000;

   reg  [8:0]               state_q;
   reg  [8:0]               state_d;
   reg                      run_q;
   reg                      fbs_en_q;
   reg                      list_running_bit;
   reg                      single_device_error_flag;
   reg  [`DEV_W-1:0]        failing_device_field;
   reg  [`SLOT_W-1:0]       queued_slot_active_bits;
   reg                      taskfile_busy_bit;
   reg                      taskfile_transfer_request_bit;
   reg  [`SLOT_W-1:0]       command_issue_bits;
   reg                      no_retx_q;
   wire [`ST_NUM-1:0]       flags;
   reg  [`ST_NUM-1:0]       set_v;
   wire [`ST_NUM-1:0]       clr_v;
   reg  [31:0]              rd_d;

   wire wr_en     = psel & penable & pwrite;
   wire rd_setup  = psel & ~penable & ~pwrite;
   wire wr_ctrl   = wr_en & (paddr == `OFF_CTRL);
   wire wr_status = wr_en & (paddr == `OFF_STATUS);
   wire wr_switch = wr_en & (paddr == `OFF_SWITCH);
   wire wr_issue  = wr_en & (paddr == `OFF_SLOTS);
   wire wr_tfile  = wr_en & (paddr == `OFF_TASKFILE);
   wire wr_queued = wr_en & (paddr == `OFF_QUEUED);
   wire slot_act  = (command_issue_bits != `ZERO32) | (queued_slot_active_bits != `ZERO32);
   wire in_loop   = state_q == S_LOOP;
   wire rx_gate   = slot_act & ~in_loop;

   // =======================================================================
   // Event classification
   wire sw_esc_reg  = fbs_en_q & esc_tx_reg;
   wire sw_esc_oth  = fbs_en_q & esc_tx_other;
   wire esc_fatal   = esc_rx_frame | esc_tx_data | (esc_tx_reg & ~fbs_en_q)
                      | (esc_tx_other & ~fbs_en_q);
   wire dma_orphan  = dma_setup_rx & ~slot_act;
   wire tf_err      = (sdb_err | reg_err | pio_err) & rx_gate;
   wire fatal_ev    = esc_fatal | rerr_tx_data | crc_rx_data | dma_orphan;
   wire nonfat_ev   = rerr_tx_nondata | crc_rx_nondata | sw_esc_oth | sw_esc_reg;
   wire sde_ev      = fbs_en_q & (tf_err | overflow | sw_esc_oth | sw_esc_reg);
   wire any_ev      = fatal_ev | nonfat_ev | tf_err | overflow | bad_pm_port;
   wire esc_enter   = (state_d == S_ESC_FAT) & (state_q != S_ESC_FAT);

   always @*
   begin
      set_v = {`ST_NUM{1'b0}};
      set_v[`ST_IFS]  = fatal_ev;
      set_v[`ST_INFS] = nonfat_ev;
      set_v[`ST_TFES] = tf_err;
      set_v[`ST_OFS]  = overflow;
      set_v[`ST_IPMS] = bad_pm_port;
   end

   assign clr_v = wr_status ? pwdata[`ST_NUM-1:0] : {`ST_NUM{1'b0}};

   err_event_log u_log
   (
      .clk    (clk),
      .rst    (rst),
      .set_in (set_v),
      .clr_in (clr_v),
      .flags  (flags)
   );

   // =======================================================================
   // State machine
   always @*
   begin
      state_d = state_q;
      case (state_q)
         S_IDLE, S_SW_IDLE:
         begin
            if (loop_test_start)
               state_d = S_LOOP;
            else if (esc_fatal)
               state_d = S_ESC_FAT;
            else if (fatal_ev)
               state_d = S_WAIT_CLR;
            else if (sw_esc_reg)
               state_d = S_ESC_SW;
            else if (sde_ev)
               state_d = S_ONE_DRV;
            else if (bad_pm_port)
               state_d = S_BADPM;
            else if (any_ev)
               state_d = S_NONFAT;
            else
               state_d = fbs_en_q ? S_SW_IDLE : S_IDLE;
         end
         S_LOOP:
            if (!run_q)
               state_d = S_IDLE;
         S_BADPM:
            state_d = S_NONFAT;
         S_ESC_FAT:
            state_d = S_WAIT_CLR;
         S_ESC_SW:
            state_d = S_ONE_DRV;
         S_ONE_DRV, S_NONFAT:
            state_d = fbs_en_q ? S_SW_IDLE : S_IDLE;
         S_WAIT_CLR:
            if (!run_q)
               state_d = S_IDLE;
         default:
            state_d = S_IDLE;
      endcase
   end

   // =======================================================================
   // State register
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         state_q <= S_IDLE;
      else
         state_q <= state_d;
   end

   // =======================================================================
   // Port control: run and switching enables
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         run_q    <= 1'b0;
         fbs_en_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         run_q    <= pwdata[`CTRL_RUN];
         fbs_en_q <= pwdata[`CTRL_FBS_EN];
      end
   end

   // =======================================================================
   // Underflow: the header byte count is written and no flag is raised
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         byte_count_we <= 1'b0;
         byte_count    <= `ZERO16;
      end
      else
      begin
         byte_count_we <= underflow;
         if (underflow)
            byte_count <= xfer_bytes;
      end
   end

   // =======================================================================
   // Taskfile bits and copies; the escape clear outranks a same-cycle software write
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         taskfile_busy_bit             <= 1'b0;
         taskfile_transfer_request_bit <= 1'b0;
         internal_busy_copy            <= 1'b0;
         internal_request_copy         <= 1'b0;
      end
      else if (esc_enter)
      begin
         taskfile_busy_bit             <= 1'b0;
         taskfile_transfer_request_bit <= 1'b0;
         internal_busy_copy            <= 1'b0;
         internal_request_copy         <= 1'b0;
      end
      else if (wr_tfile)
      begin
         taskfile_busy_bit             <= pwdata[`TF_BSY];
         taskfile_transfer_request_bit <= pwdata[`TF_DRQ];
         internal_busy_copy            <= pwdata[`TF_BSY];
         internal_request_copy         <= pwdata[`TF_DRQ];
      end
   end

   // =======================================================================
   // Retransmit block: set by any transmit escape, released by the next list start
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         no_retx_q <= 1'b0;
      else if (esc_tx_data | esc_tx_reg | esc_tx_other)
         no_retx_q <= 1'b1;
      else if (list_start)
         no_retx_q <= 1'b0;
   end

   // =======================================================================
   // Slot registers empty when the port stops, so a stale slot cannot gate the next run
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         command_issue_bits      <= `ZERO32;
         queued_slot_active_bits <= `ZERO32;
      end
      else if (!run_q)
      begin
         command_issue_bits      <= `ZERO32;
         queued_slot_active_bits <= `ZERO32;
      end
      else
      begin
         if (wr_issue)
            command_issue_bits <= command_issue_bits | pwdata;
         if (sdb_err & rx_gate)
            queued_slot_active_bits <= queued_slot_active_bits & ~sdb_clear_slots;
         else if (wr_queued)
            queued_slot_active_bits <= queued_slot_active_bits | pwdata;
      end
   end

   // =======================================================================
   // Single drive error: hardware set wins over the software clear
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         single_device_error_flag <= 1'b0;
         failing_device_field     <= `ZERO4;
      end
      else if (sde_ev)
      begin
         single_device_error_flag <= 1'b1;
         failing_device_field     <= frame_dev;
      end
      else if (wr_switch & pwdata[`SW_SDE])
         single_device_error_flag <= 1'b0;
   end

   // =======================================================================
   // Command list running indication
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         list_running_bit <= 1'b0;
      else if (!run_q)
         list_running_bit <= 1'b0;
      else if (list_start)
         list_running_bit <= 1'b1;
   end

   // =======================================================================
   // Datapath controls
   // Posting stays open after a fatal data error so the drive can finish
   assign post_enable      = run_q & ~in_loop;
   assign drop_frame       = other_rx & ~dma_setup_rx & ~slot_act;
   assign retransmit_block = no_retx_q;

   // =======================================================================
   // APB slave: zero wait, unmapped reads zero with error
   wire mapped = (paddr == `OFF_CTRL) | (paddr == `OFF_STATUS) | (paddr == `OFF_SWITCH)
                 | (paddr == `OFF_SLOTS) | (paddr == `OFF_QUEUED)
                 | (paddr == `OFF_TASKFILE) | (paddr == `OFF_STATE);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always @*
   begin
      rd_d = `ZERO32;
      case (paddr)
         `OFF_CTRL:     rd_d = {30'h0000_0000, fbs_en_q, run_q};
         `OFF_STATUS:   rd_d = {23'h00_0000, list_running_bit, 3'h0, flags};
         `OFF_SWITCH:   rd_d = {20'h0_0000, failing_device_field, 7'h00,
                                single_device_error_flag};
         `OFF_SLOTS:    rd_d = command_issue_bits;
         `OFF_QUEUED:   rd_d = queued_slot_active_bits;
         `OFF_TASKFILE: rd_d = {24'h00_0000, taskfile_busy_bit, 3'h0,
                                taskfile_transfer_request_bit, 3'h0};
         `OFF_STATE:    rd_d = {23'h00_0000, state_q};
         default:       rd_d = `ZERO32;
      endcase
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         prdata <= `ZERO32;
      else if (rd_setup)
         prdata <= rd_d;
   end
endmodule

// ===== verif/drive_model.sv
`timescale 1ns/1ns
// ==========================================================
// Drive side: one frame event per request from the bench
module drive_model
(
   input  logic        clk,
   input  logic        rst,
   input  logic        fire,
   input  logic [4:0]  kind,
   input  logic [3:0]  dev,
   input  logic [15:0] val,
   output logic [17:0] ev,
   output logic [3:0]  frame_dev,
   output logic [15:0] xfer,
   output logic [31:0] slots
);
   // Side data toggles between events so a stale value is never mistaken for a fresh one
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ev <= 18'h0_0000;
         frame_dev <= 4'h0;
         xfer <= 16'h0000;
         slots <= 32'h0000_0000;
      end
      else
      begin
         ev <= fire ? 18'h0_0001 << kind : 18'h0_0000;
         frame_dev <= fire ? dev : ~frame_dev;
         xfer <= fire ? val : ~xfer;
         slots <= fire ? {val, val} : ~slots;
      end
   end
endmodule

// ===== verif/err_port_chk_sva.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker
module err_port_chk
(
   input logic        clk,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic [11:0] paddr,
   input logic        pready,
   input logic        pslverr,
   input logic        underflow,
   input logic [15:0] xfer_bytes,
   input logic        byte_count_we,
   input logic [15:0] byte_count,
   input logic        esc_tx_data,
   input logic        esc_tx_reg,
   input logic        esc_tx_other,
   input logic        list_start,
   input logic        retransmit_block,
   input logic        drop_frame,
   input logic        other_rx,
   input logic        dma_setup_rx,
   input logic        internal_busy_copy,
   input logic        internal_request_copy
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire tx_esc = esc_tx_data | esc_tx_reg | esc_tx_other;

   a_ready_const: assert property (pready)
      else $error("pready dropped");
   a_bad_addr: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
      else $error("unmapped access not refused");
   a_count_load: assert property (underflow |=> byte_count_we && byte_count == $past(xfer_bytes))
      else $error("byte count not recorded");
   a_count_cause: assert property (byte_count_we |-> $past(underflow))
      else $error("byte count written without underflow");
   a_tx_block: assert property (tx_esc && !list_start |=> retransmit_block)
      else $error("escaped frame not blocked");
   a_block_hold: assert property (retransmit_block && !list_start |=> retransmit_block)
      else $error("retransmit block released early");
   a_drop_cause: assert property (drop_frame |-> other_rx && !dma_setup_rx)
      else $error("drop without cause");
   a_dma_kept: assert property (dma_setup_rx |-> !drop_frame)
      else $error("dma setup dropped");
   a_esc_clear: assert property (esc_tx_data |-> ##[1:3] !internal_busy_copy && !internal_request_copy)
      else $error("busy copies not cleared");

   c_underflow: cover property (underflow ##1 byte_count_we);
   c_drop: cover property (drop_frame);
   c_block: cover property ($rose(retransmit_block));
endmodule

bind port_error_handling_fsm err_port_chk chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .underflow(underflow), .xfer_bytes(xfer_bytes),
   .byte_count_we(byte_count_we), .byte_count(byte_count), .esc_tx_data(esc_tx_data), .esc_tx_reg(esc_tx_reg),
   .esc_tx_other(esc_tx_other), .list_start(list_start), .retransmit_block(retransmit_block),
   .drop_frame(drop_frame), .other_rx(other_rx), .dma_setup_rx(dma_setup_rx),
   .internal_busy_copy(internal_busy_copy), .internal_request_copy(internal_request_copy));

// ===== verif/port_error_handling_fsm_tb.sv
`timescale 1ns/1ns
module port_error_handling_fsm_tb;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, pready, pslverr, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, slots, slot, qs;
   logic [4:0]  kind = 0;
   logic [3:0]  dev = 0, fdev;
   logic [15:0] val = 0, xfer, bc;
   logic [17:0] ev;
   logic [5:0]  e;
   logic        bcwe, post_en, drop, rtb, ibc, irc;
   int          fail_count = 0, num_checks = 0;

   always #50 clk = ~clk;

   drive_model drive (.clk(clk), .rst(rst), .fire(fire), .kind(kind), .dev(dev), .val(val), .ev(ev),
      .frame_dev(fdev), .xfer(xfer), .slots(slots));

   port_error_handling_fsm DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .loop_test_start(ev[0]), .esc_rx_frame(ev[1]), .esc_tx_data(ev[2]), .esc_tx_reg(ev[3]),
      .esc_tx_other(ev[4]), .rerr_tx_data(ev[5]), .rerr_tx_nondata(ev[6]), .crc_rx_data(ev[7]),
      .crc_rx_nondata(ev[8]), .sdb_err(ev[9]), .sdb_clear_slots(slots), .reg_err(ev[10]), .pio_err(ev[11]),
      .dma_setup_rx(ev[12]), .other_rx(ev[13]), .overflow(ev[14]), .underflow(ev[15]), .xfer_bytes(xfer),
      .bad_pm_port(ev[16]), .frame_dev(fdev), .list_start(ev[17]), .post_enable(post_en), .drop_frame(drop),
      .retransmit_block(rtb), .byte_count_we(bcwe), .byte_count(bc), .internal_busy_copy(ibc),
      .internal_request_copy(irc));

   // Expected flags {single drive, bad port, overflow, taskfile, nonfatal, fatal}
   function automatic logic [5:0] expf(input int k, input bit fbs);
      case (k)
         1, 2, 5, 7, 12: return 6'h01;
         3, 4:           return fbs ? 6'h22 : 6'h01;
         6, 8:           return 6'h02;
         9, 10, 11:      return fbs ? 6'h24 : 6'h04;
         14:             return fbs ? 6'h28 : 6'h08;
         16:             return 6'h10;
         default:        return 6'h00;
      endcase
   endfunction

   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      num_checks++;
      if (x !== s)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic pulse(input int k);
      @(posedge clk);
      fire <= 1; kind <= k; dev <= $urandom; val <= $urandom;
      @(posedge clk);
      fire <= 0;
      repeat (3) @(posedge clk);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(38483));
      repeat (6) @(posedge clk);
      rst <= 0;
      apb(0, 12'h004, 0); chk("status reset", 0, rd);
      apb(0, 12'h020, 0); chk("unmapped err", 1, err); chk("unmapped read", 0, rd);
      apb(1, 12'h000, 1); pulse(0); chk("post in loop", 0, post_en);
      apb(1, 12'h000, 1); apb(0, 12'h014, 0); chk("loop held", 1, rd[2]);
      apb(1, 12'h000, 0); apb(0, 12'h014, 0); chk("loop left", 0, rd[2]);
      $display("test loop_state done");
      for (int fbs = 0; fbs < 2; fbs++)
         for (int k = 1; k <= 16; k++)
         begin
            apb(1, 12'h000, 0); apb(1, 12'h004, 32'h0000_001F); apb(1, 12'h008, 1);
            apb(1, 12'h000, {30'h0, fbs[0], 1'b1}); pulse(17);
            slot = 32'h0000_0001 << ($urandom % 32);
            // No active slot for the two frames whose handling depends on its absence
            if (k != 12 && k != 13) apb(1, 12'h00c, slot);
            // Busy and request set so that an escape has something to clear
            apb(1, 12'h010, 32'h0000_0088);
            qs = $urandom;
            if (k == 9) apb(1, 12'h018, qs);
            pulse(k);
            e = expf(k, fbs);
            apb(0, 12'h004, 0); chk("status flags", e[4:0], rd[4:0]);
            if (k == 5 || k == 7) chk("post open", 1, post_en);
            apb(0, 12'h010, 0);
            if (k == 2 || (k == 3 && !fbs)) chk("busy cleared", 0, rd);
            else if (k >= 5) chk("taskfile kept", 32'h0000_0088, rd);
            if (k == 9) apb(0, 12'h018, 0);
            if (k == 9) chk("queued slots", qs & ~{val, val}, rd);
            apb(0, 12'h008, 0); chk("single drive", e[5], rd[0]);
            if (e[5]) chk("failing drive", dev, rd[11:8]);
            if (k <= 4) begin apb(0, 12'h00c, 0); chk("issue kept", slot, rd); end
            if (k == 15) chk("byte count", val, bc);
            if (e[4:1] != 0 && !e[0] && !e[5])
            begin
               apb(0, 12'h014, 0); chk("idle again", 32'h1 << fbs, rd & 32'h0000_01FF);
            end
            if (!fbs && e[0])
            begin
               apb(0, 12'h014, 0); chk("fatal held", 1, rd[8]);
               apb(1, 12'h000, 0); apb(0, 12'h004, 0); chk("list stop", 0, rd[8]);
               apb(0, 12'h014, 0); chk("fatal cleared", 0, rd[8]);
            end
            $display("test kind %0d switching %0d done", k, fbs);
         end
      tally_and_finish();
   end
endmodule
